/* hdl/mmic_fabric.sv */
`include "mmic_cfg.svh"
// Notes on behaviour
// - Zero to four stages per path
// - Handshake crossing: one transfer in flight
// - FIFO crossing allows several outstanding transfers
// - Auto: FIFO for bursts, else handshake
// - Unmapped accesses go to default responder
// - Default responder answers with error
// - Burst adapter generic or per-type form
// - ECC off by default; failure gives decode error
// - Synchronous reset option for all fabric registers except FIFO storage, which is not reset
// - Reset held at least sixteen cycles
// - No transaction until sixteen cycles after reset
// - Masters and slaves reset together
// - Slave resets only after answering outstanding
// - Attached components keep own reset style
// - Instrumentation counters when enabled
module mmic_pipe #(
  parameter int W      = 8,
  parameter int STAGES = `MMIC_PIPE_DEF
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arstN,
  input  wire logic         srst,
  // Upstream
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Downstream
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  generate
    if (STAGES == 0) begin : g_comb
      // Straight wires, no added latency
      assign outValid = inValid;
      assign outData  = inData;
      assign inReady  = outReady;
    end else begin : g_reg
      logic [STAGES-1:0] v_r, v_nxt;
      logic [W-1:0]      d_r   [STAGES];
      logic [W-1:0]      d_nxt [STAGES];
      logic [STAGES:0]   rdy;
      // A stage loads when empty or when its successor moves
      always_comb begin
        rdy[STAGES] = outReady;
        for (int i = STAGES - 1; i >= 0; i--) rdy[i] = !v_r[i] || rdy[i+1];
        v_nxt = v_r;
        d_nxt = d_r;
        if (rdy[0]) begin
          v_nxt[0] = inValid;
          d_nxt[0] = inData;
        end
        for (int i = 1; i < STAGES; i++) begin
          if (rdy[i]) begin
            v_nxt[i] = v_r[i-1];
            d_nxt[i] = d_r[i-1];
          end
        end
      end
      // Stage registers
      always_ff @(posedge clk or negedge arstN) begin
        if (!arstN) begin
          v_r <= '0;
          for (int i = 0; i < STAGES; i++) d_r[i] <= '0;
        end else if (srst) begin
          v_r <= '0;
          for (int i = 0; i < STAGES; i++) d_r[i] <= '0;
        end else begin
          v_r <= v_nxt;
          d_r <= d_nxt;
        end
      end
      assign inReady  = rdy[0];
      assign outValid = v_r[STAGES-1];
      assign outData  = d_r[STAGES-1];
    end
  endgenerate
endmodule

module mmic_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `MMIC_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         arstN,
  input  wire logic         srst,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
  logic         push, pop;

  // Extra pointer bit tells full from empty
  assign inReady  = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign outValid = (wp_r != rp_r);
  assign outData  = mem[rp_r[AW-1:0]];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer update
  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  // Pointer registers
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      wp_r <= '0;
      rp_r <= '0;
    end else if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage, not reset
  always_ff @(posedge clk) begin
    if (push) mem[wp_r[AW-1:0]] <= inData;
  end
endmodule

module mmic_fabric #(
  parameter int                   PIPE_STAGES   = `MMIC_PIPE_DEF,
  parameter mmic_pkg::mmic_cross_t CROSS_TYPE   = mmic_pkg::CROSS_AUTO,
  parameter bit                   BURST_LINK    = 1'b1,
  parameter mmic_pkg::mmic_impl_t BURST_IMPL    = mmic_pkg::IMPL_GENERIC,
  parameter bit                   ECC_EN        = 1'b0,
  parameter bit                   DEFAULT_SLAVE = 1'b1,
  parameter bit                   INSTR_EN      = 1'b0,
  parameter bit                   SYNC_RST      = 1'b0,
  parameter int                   FIFO_DEPTH    = `MMIC_FIFO_DEPTH,
  parameter logic [`MMIC_ADDR_W-1:0] SLV_BASE   = `MMIC_SLV_BASE,
  parameter logic [`MMIC_ADDR_W-1:0] SLV_SPAN   = `MMIC_SLV_SPAN
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    nrst,
  // Master side
  mmic_if.fabric_end                   bus,
  // Slave side
  output logic                         sCmdValid,
  input  wire logic                    sCmdReady,
  output mmic_pkg::mmic_cmd_t          sCmd,
  input  wire logic                    sRspValid,
  output logic                         sRspReady,
  input  wire logic [`MMIC_DATA_W-1:0] sRspData,
  input  wire logic                    sRspErr,
  // Memory fault injection
  input  wire logic                    eccInject,
  // Instrumentation
  output logic [`MMIC_CNT_W-1:0]       dbgCmdCount,
  output logic [`MMIC_CNT_W-1:0]       dbgRspCount,
  output logic [`MMIC_CNT_W-1:0]       dbgErrCount,
  output logic [`MMIC_CNT_W-1:0]       dbgBusyCycles
);
  localparam int CW  = $bits(mmic_pkg::mmic_cmd_t);
  localparam int RW  = $bits(mmic_pkg::mmic_resp_t);
  localparam int OW  = $clog2(FIFO_DEPTH) + 1;
  localparam bit USE_FIFO = (CROSS_TYPE == mmic_pkg::CROSS_FIFO) ||
                            ((CROSS_TYPE == mmic_pkg::CROSS_AUTO) && BURST_LINK);

  logic                 rstN, arstN, srst;
  logic                 pValid, pReady, fInReady, fOutValid, fOutReady, eccBad;
  mmic_pkg::mmic_cmd_t  pCmd, tCmd;
  logic [CW:0]          fIn, fOut;
  logic                 tValid, tTake, toErr, hit, hsValid;
  logic                 rValid, rReady, rTake;
  mmic_pkg::mmic_resp_t rData;
  logic [`MMIC_ADDR_W-1:0] step, aGen, aWrap, aType;

  // Only the fabric's own registers follow the reset style
  assign rstN  = nrst && bus.icRstN;
  assign arstN = SYNC_RST ? 1'b1 : rstN;
  assign srst  = SYNC_RST ? !rstN : 1'b0;

  // Command path stages
  mmic_pipe #(.W(CW), .STAGES(PIPE_STAGES)) uCmdPipe (
    .clk(clk), .arstN(arstN), .srst(srst),
    .inValid(bus.cmdValid), .inReady(bus.cmdReady), .inData(bus.cmd),
    .outValid(pValid), .outReady(pReady), .outData(pCmd)
  );

  // FIFO crossing with parity over stored words
  assign fIn = {(ECC_EN ? ^pCmd : 1'b0) ^ eccInject, pCmd};
  mmic_fifo #(.W(CW + 1), .DEPTH(FIFO_DEPTH)) uXFifo (
    .clk(clk), .arstN(arstN), .srst(srst),
    .inValid(USE_FIFO && pValid), .inReady(fInReady), .inData(fIn),
    .outValid(fOutValid), .outReady(fOutReady), .outData(fOut)
  );
  assign eccBad = ECC_EN && (^fOut);

  // Handshake crossing state
  logic busy_r, busy_nxt, reqTgl_r, reqTgl_nxt, reqS1_r, reqS2_r, reqSeen_r, reqSeen_nxt;
  logic ackTgl_r, ackTgl_nxt, ackS1_r, ackS2_r, ackSeen_r, ackSeen_nxt;
  mmic_pkg::mmic_cmd_t hold_r, hold_nxt;
  logic [OW-1:0] outst_r, outst_nxt;
  logic          errPend_r, errPend_nxt;

  assign hsValid   = (reqS2_r != reqSeen_r);
  assign pReady    = USE_FIFO ? fInReady : !busy_r;
  assign tValid    = USE_FIFO ? fOutValid : hsValid;
  assign tCmd      = USE_FIFO ? mmic_pkg::mmic_cmd_t'(fOut[CW-1:0]) : hold_r;
  assign fOutReady = USE_FIFO && tTake;

  // Decode: misses and memory faults go to the default responder
  assign hit   = (tCmd.addr - SLV_BASE) < SLV_SPAN;
  assign toErr = (USE_FIFO && eccBad) || (DEFAULT_SLAVE && !hit);
  assign sCmdValid = tValid && !toErr && (outst_r != OW'(FIFO_DEPTH));
  assign tTake = toErr ? (tValid && !errPend_r && outst_r == '0) : (sCmdValid && sCmdReady);

  // Burst address conversion in either build form
  assign step  = (`MMIC_ADDR_W'(tCmd.beat)) << `MMIC_BEAT_SHIFT;
  assign aWrap = (tCmd.addr & ~`MMIC_WRAP_MASK) | ((tCmd.addr + step) & `MMIC_WRAP_MASK);
  assign aGen  = (tCmd.burst == mmic_pkg::BURST_FIXED) ? tCmd.addr :
                 (tCmd.burst == mmic_pkg::BURST_WRAP) ? aWrap : tCmd.addr + step;
  always_comb begin
    case (tCmd.burst)
      mmic_pkg::BURST_FIXED: aType = tCmd.addr;
      mmic_pkg::BURST_INCR:  aType = tCmd.addr + step;
      mmic_pkg::BURST_WRAP:  aType = aWrap;
      default:               aType = tCmd.addr;
    endcase
  end
  always_comb begin
    sCmd      = tCmd;
    sCmd.addr = (BURST_IMPL == mmic_pkg::IMPL_GENERIC) ? aGen : aType;
  end

  // Response merge: error answers only when the slave is idle
  assign rValid    = errPend_r || sRspValid;
  assign rData     = errPend_r ? mmic_pkg::mmic_resp_t'{mmic_pkg::RSP_DECERR, '0} :
                     mmic_pkg::mmic_resp_t'{sRspErr ? mmic_pkg::RSP_SLVERR : mmic_pkg::RSP_OKAY, sRspData};
  assign sRspReady = !errPend_r && rReady;
  assign rTake     = rValid && rReady;

  // Crossing, outstanding and default responder next state
  always_comb begin
    busy_nxt    = busy_r;
    hold_nxt    = hold_r;
    reqTgl_nxt  = reqTgl_r;
    reqSeen_nxt = reqSeen_r;
    ackTgl_nxt  = ackTgl_r;
    ackSeen_nxt = ackSeen_r;
    if (!USE_FIFO && !busy_r && pValid) begin
      busy_nxt   = 1'b1;
      hold_nxt   = pCmd;
      reqTgl_nxt = !reqTgl_r;
    end
    if (!USE_FIFO && hsValid && tTake) reqSeen_nxt = reqS2_r;
    if (!USE_FIFO && rTake) ackTgl_nxt = !ackTgl_r;
    if (ackS2_r != ackSeen_r) begin
      ackSeen_nxt = ackS2_r;
      busy_nxt    = 1'b0;
    end
    outst_nxt   = outst_r + OW'(sCmdValid && sCmdReady) - OW'(sRspValid && sRspReady);
    errPend_nxt = (errPend_r && !rTake) || (toErr && tTake);
  end

  // Crossing registers; each first synchroniser stage feeds only its second stage
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      busy_r <= 1'b0; hold_r <= '0; reqTgl_r <= 1'b0; reqS1_r <= 1'b0; reqS2_r <= 1'b0;
      reqSeen_r <= 1'b0; ackTgl_r <= 1'b0; ackS1_r <= 1'b0; ackS2_r <= 1'b0; ackSeen_r <= 1'b0;
      outst_r <= '0; errPend_r <= 1'b0;
    end else if (srst) begin
      busy_r <= 1'b0; hold_r <= '0; reqTgl_r <= 1'b0; reqS1_r <= 1'b0; reqS2_r <= 1'b0;
      reqSeen_r <= 1'b0; ackTgl_r <= 1'b0; ackS1_r <= 1'b0; ackS2_r <= 1'b0; ackSeen_r <= 1'b0;
      outst_r <= '0; errPend_r <= 1'b0;
    end else begin
      busy_r    <= busy_nxt;
      hold_r    <= hold_nxt;
      reqTgl_r  <= reqTgl_nxt;
      reqS1_r   <= reqTgl_r;
      reqS2_r   <= reqS1_r;
      reqSeen_r <= reqSeen_nxt;
      ackTgl_r  <= ackTgl_nxt;
      ackS1_r   <= ackTgl_r;
      ackS2_r   <= ackS1_r;
      ackSeen_r <= ackSeen_nxt;
      outst_r   <= outst_nxt;
      errPend_r <= errPend_nxt;
    end
  end

  // Response path stages
  mmic_pipe #(.W(RW), .STAGES(PIPE_STAGES)) uRspPipe (
    .clk(clk), .arstN(arstN), .srst(srst),
    .inValid(rValid), .inReady(rReady), .inData(rData),
    .outValid(bus.rspValid), .outReady(bus.rspReady), .outData(bus.rsp)
  );

  // Performance counters seen at the master port
  logic [`MMIC_CNT_W-1:0] cCmd_r, cCmd_nxt, cRsp_r, cRsp_nxt, cErr_r, cErr_nxt, cBusy_r, cBusy_nxt;
  always_comb begin
    cCmd_nxt  = cCmd_r;
    cRsp_nxt  = cRsp_r;
    cErr_nxt  = cErr_r;
    cBusy_nxt = cBusy_r;
    if (INSTR_EN) begin
      if (bus.cmdValid && bus.cmdReady) cCmd_nxt = cCmd_r + 1'b1;
      if (bus.rspValid && bus.rspReady) cRsp_nxt = cRsp_r + 1'b1;
      if (bus.rspValid && bus.rspReady && bus.rsp.code != mmic_pkg::RSP_OKAY) cErr_nxt = cErr_r + 1'b1;
      if (cCmd_r != cRsp_r) cBusy_nxt = cBusy_r + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      cCmd_r <= '0; cRsp_r <= '0; cErr_r <= '0; cBusy_r <= '0;
    end else if (srst) begin
      cCmd_r <= '0; cRsp_r <= '0; cErr_r <= '0; cBusy_r <= '0;
    end else begin
      cCmd_r  <= cCmd_nxt;
      cRsp_r  <= cRsp_nxt;
      cErr_r  <= cErr_nxt;
      cBusy_r <= cBusy_nxt;
    end
  end
  assign dbgCmdCount   = cCmd_r;
  assign dbgRspCount   = cRsp_r;
  assign dbgErrCount   = cErr_r;
  assign dbgBusyCycles = cBusy_r;
endmodule

/* hdl/mmic_cfg.svh */
`ifndef MMIC_CFG_SVH
`define MMIC_CFG_SVH
// Bus widths
`define MMIC_ADDR_W 32
`define MMIC_DATA_W 32
`define MMIC_BEAT_W 4
`define MMIC_CNT_W 32
// Pipeline and buffer sizes
`define MMIC_PIPE_DEF 1
`define MMIC_PIPE_MAX 4
`define MMIC_FIFO_DEPTH 8
// Burst address stepping
`define MMIC_BEAT_SHIFT 2
`define MMIC_WRAP_MASK 32'h0000000f
// Mapped slave region
`define MMIC_SLV_BASE 32'h00000000
`define MMIC_SLV_SPAN 32'h00010000
// Reset sequencing in clock cycles, and the width in bits of its counter
`define MMIC_RST_HOLD_CYC 16
`define MMIC_RST_WAIT_CYC 16
`define MMIC_RST_CNT_W 5
`endif

/* hdl/mmic_pkg.sv */
`include "mmic_cfg.svh"
package mmic_pkg;
  // Crossing adapter style
  typedef enum logic [1:0] {CROSS_HS, CROSS_FIFO, CROSS_AUTO} mmic_cross_t;
  // Adapter build form
  typedef enum logic {IMPL_GENERIC, IMPL_PER_TYPE} mmic_impl_t;
  // Burst type and response code
  typedef enum logic [1:0] {BURST_FIXED, BURST_INCR, BURST_WRAP} mmic_burst_t;
  typedef enum logic [1:0] {RSP_OKAY, RSP_SLVERR, RSP_DECERR} mmic_rsp_t;
  // Master end sequencer
  typedef enum logic [1:0] {MS_RESET, MS_WAIT, MS_RUN} mmic_mstate_t;
  // Command word
  typedef struct packed {
    logic                      write;
    logic [`MMIC_ADDR_W-1:0]   addr;
    logic [`MMIC_DATA_W-1:0]   wdata;
    mmic_burst_t               burst;
    logic [`MMIC_BEAT_W-1:0]   beat;
  } mmic_cmd_t;
  // Response word
  typedef struct packed {
    mmic_rsp_t                 code;
    logic [`MMIC_DATA_W-1:0]   rdata;
  } mmic_resp_t;
endpackage

/* hdl/mmic_if.sv */
interface mmic_if;
  // Command channel
  logic                  cmdValid;
  logic                  cmdReady;
  mmic_pkg::mmic_cmd_t   cmd;
  // Response channel
  logic                  rspValid;
  logic                  rspReady;
  mmic_pkg::mmic_resp_t  rsp;
  // Interconnect reset from the master end
  logic                  icRstN;

  modport master_end (output cmdValid, cmd, rspReady, icRstN, input cmdReady, rspValid, rsp);
  modport fabric_end (input cmdValid, cmd, rspReady, icRstN, output cmdReady, rspValid, rsp);
endinterface

/* hdl/mmic_master_end.sv */
`include "mmic_cfg.svh"
module mmic_master_end (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Interconnect side
  mmic_if.master_end                     bus,
  // User request
  input  wire logic                      uReqValid,
  output logic                           uReqReady,
  input  wire logic                      uReqWrite,
  input  wire logic [`MMIC_ADDR_W-1:0]   uReqAddr,
  input  wire logic [`MMIC_DATA_W-1:0]   uReqWdata,
  input  wire mmic_pkg::mmic_burst_t     uReqBurst,
  input  wire logic [`MMIC_BEAT_W-1:0]   uReqBeat,
  // User response
  output logic                           uRspValid,
  output logic [`MMIC_DATA_W-1:0]        uRspData,
  output mmic_pkg::mmic_rsp_t            uRspCode,
  // Slave reset control
  input  wire logic                      slvRstReqN,
  output logic                           slvRstN,
  // Status
  output logic                           running
);
  localparam int OW = $clog2(`MMIC_FIFO_DEPTH) + 2;

  mmic_pkg::mmic_mstate_t          st_r, st_nxt;
  logic [`MMIC_RST_CNT_W-1:0]      cnt_r, cnt_nxt;
  logic                            icRstN_r, icRstN_nxt;
  logic                            cmdValid_r, cmdValid_nxt;
  mmic_pkg::mmic_cmd_t             cmd_r, cmd_nxt;
  logic                            rspV_r, rspV_nxt;
  mmic_pkg::mmic_resp_t            rsp_r, rsp_nxt;
  logic [OW-1:0]                   outst_r, outst_nxt;
  logic                            slvRstN_r, slvRstN_nxt;
  logic                            take, done;

  // New requests stop once the slave reset is requested
  assign uReqReady = (st_r == mmic_pkg::MS_RUN) && slvRstReqN && slvRstN_r && (!cmdValid_r || bus.cmdReady);
  assign take      = uReqValid && uReqReady;
  assign done      = bus.rspValid;

  // Reset stretch, settle wait, request and response registers
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    icRstN_nxt   = icRstN_r;
    cmdValid_nxt = cmdValid_r;
    cmd_nxt      = cmd_r;
    case (st_r)
      mmic_pkg::MS_RESET: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `MMIC_RST_CNT_W'(`MMIC_RST_HOLD_CYC - 1)) begin
          icRstN_nxt = 1'b1;
          cnt_nxt    = '0;
          st_nxt     = mmic_pkg::MS_WAIT;
        end
      end
      mmic_pkg::MS_WAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == `MMIC_RST_CNT_W'(`MMIC_RST_WAIT_CYC - 1)) begin
          st_nxt = mmic_pkg::MS_RUN;
        end
      end
      mmic_pkg::MS_RUN: begin
        if (bus.cmdReady) begin
          cmdValid_nxt = 1'b0;
        end
        if (take) begin
          cmdValid_nxt = 1'b1;
          cmd_nxt      = '{uReqWrite, uReqAddr, uReqWdata, uReqBurst, uReqBeat};
        end
      end
      default: st_nxt = mmic_pkg::MS_RESET;
    endcase
    rspV_nxt  = done;
    rsp_nxt   = done ? bus.rsp : rsp_r;
    outst_nxt = outst_r + OW'(take) - OW'(done);
    // Slave enters reset only with nothing outstanding
    if (slvRstReqN) begin
      slvRstN_nxt = 1'b1;
    end else if (outst_r == '0 && !cmdValid_r) begin
      slvRstN_nxt = 1'b0;
    end else begin
      slvRstN_nxt = slvRstN_r;
    end
  end

  // Master, interconnect and slaves share one reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r       <= mmic_pkg::MS_RESET;
      cnt_r      <= '0;
      icRstN_r   <= 1'b0;
      cmdValid_r <= 1'b0;
      cmd_r      <= '0;
      rspV_r     <= 1'b0;
      rsp_r      <= '0;
      outst_r    <= '0;
      slvRstN_r  <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      icRstN_r   <= icRstN_nxt;
      cmdValid_r <= cmdValid_nxt;
      cmd_r      <= cmd_nxt;
      rspV_r     <= rspV_nxt;
      rsp_r      <= rsp_nxt;
      outst_r    <= outst_nxt;
      slvRstN_r  <= slvRstN_nxt;
    end
  end

  // Outputs
  assign bus.cmdValid = cmdValid_r;
  assign bus.cmd      = cmd_r;
  assign bus.rspReady = 1'b1;
  assign bus.icRstN   = icRstN_r;
  assign uRspValid    = rspV_r;
  assign uRspData     = rsp_r.rdata;
  assign uRspCode     = rsp_r.code;
  assign slvRstN      = slvRstN_r;
  assign running      = (st_r == mmic_pkg::MS_RUN);
endmodule

/* tb/mmic_fabric_asserts.sv */
module mmic_fabric_asserts (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // Interface signals
  input wire logic                 cmdValid,
  input wire logic                 cmdReady,
  input wire mmic_pkg::mmic_cmd_t  cmd,
  input wire logic                 rspValid,
  input wire logic                 rspReady,
  input wire mmic_pkg::mmic_resp_t rsp,
  input wire logic                 icRstN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lowCnt_r;
  logic [7:0] hiCnt_r;
  logic [7:0] outCnt_r;
  // Cycles in and out of interconnect reset, transfers in flight
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lowCnt_r <= 8'h00;
      hiCnt_r  <= 8'h00;
      outCnt_r <= 8'h00;
    end else begin
      lowCnt_r <= icRstN ? 8'h00 : lowCnt_r + 8'(lowCnt_r != 8'hff);
      hiCnt_r  <= !icRstN ? 8'h00 : hiCnt_r + 8'(hiCnt_r != 8'hff);
      outCnt_r <= !icRstN ? 8'h00 : outCnt_r + 8'(cmdValid && cmdReady) - 8'(rspValid && rspReady);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rst_hold; $rose(icRstN) |-> lowCnt_r >= 8'h10; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("interconnect reset too short");
  property p_wait_start; cmdValid |-> hiCnt_r >= 8'h10; endproperty
  a_wait_start: assert property (p_wait_start) else $error("command too soon after reset");
  property p_rst_low; $rose(nrst) |-> !icRstN [*8]; endproperty
  a_rst_low: assert property (p_rst_low) else $error("interconnect reset not held");
  property p_quiet; !icRstN |-> !cmdValid && !rspValid; endproperty
  a_quiet: assert property (p_quiet) else $error("valid during reset");
  property p_cmd_hold; cmdValid && !cmdReady |=> cmdValid && $stable(cmd); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("stalled command changed");
  property p_no_orphan; rspValid |-> outCnt_r != 8'h00; endproperty
  a_no_orphan: assert property (p_no_orphan) else $error("response without command");
  property p_dec_data; rspValid && rsp.code == mmic_pkg::RSP_DECERR |-> rsp.rdata == 32'h0; endproperty
  a_dec_data: assert property (p_dec_data) else $error("error response carries data");
  property p_answer; cmdValid && cmdReady |-> ##[1:500] rspValid; endproperty
  a_answer: assert property (p_answer) else $error("command left pending");
endmodule

/* tb/tb_mm_interconnect_build_options.sv */
module tb_mm_interconnect_build_options;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk, nrst, uReqValid, uReqReady, uReqWrite, uRspValid, slvRstReqN, slvRstN, running;
  logic                  sCmdValid, sCmdReady, sRspValid, sRspReady, sRspErr, eccInject, acc, sTake, rTake, stall;
  logic [31:0]           uReqAddr, uReqWdata, uRspData, sRspData, sAddr, dbgCmdCount, dbgRspCount, r;
  logic [31:0]           dbgErrCount, dbgBusyCycles;
  logic [3:0]            uReqBeat;
  mmic_pkg::mmic_burst_t uReqBurst;
  mmic_pkg::mmic_rsp_t   uRspCode;
  mmic_pkg::mmic_cmd_t   sCmd;
  logic [33:0]           expQ[$];
  logic [31:0]           slvQ[$];
  integer                seed = 32'h2c95;
  int                    nMismatch, checks, cyc, issued, nAcc, nErr;
  bit                    ok;
  mmic_if mmic_if_i ();
  mmic_master_end mmic_master_end_i (.clk(clk), .nrst(nrst), .bus(mmic_if_i), .uReqValid(uReqValid),
    .uReqReady(uReqReady), .uReqWrite(uReqWrite), .uReqAddr(uReqAddr), .uReqWdata(uReqWdata),
    .uReqBurst(uReqBurst), .uReqBeat(uReqBeat), .uRspValid(uRspValid), .uRspData(uRspData),
    .uRspCode(uRspCode), .slvRstReqN(slvRstReqN), .slvRstN(slvRstN), .running(running));
  mmic_fabric #(.PIPE_STAGES(2), .ECC_EN(1'b1), .INSTR_EN(1'b1), .SYNC_RST(1'b1)) mmic_fabric_i (
    .clk(clk), .nrst(nrst), .bus(mmic_if_i), .sCmdValid(sCmdValid), .sCmdReady(sCmdReady), .sCmd(sCmd),
    .sRspValid(sRspValid), .sRspReady(sRspReady), .sRspData(sRspData), .sRspErr(sRspErr),
    .eccInject(eccInject), .dbgCmdCount(dbgCmdCount), .dbgRspCount(dbgRspCount), .dbgErrCount(dbgErrCount),
    .dbgBusyCycles(dbgBusyCycles));
  mmic_fabric_asserts mmic_fabric_asserts_i (.clk(clk), .nrst(nrst), .cmdValid(mmic_if_i.cmdValid),
    .cmdReady(mmic_if_i.cmdReady), .cmd(mmic_if_i.cmd), .rspValid(mmic_if_i.rspValid),
    .rspReady(mmic_if_i.rspReady), .rsp(mmic_if_i.rsp), .icRstN(mmic_if_i.icRstN));
  // Clock at 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Expected answer for a beat address: data pattern, slave error where address bits 11:8 are all ones, decode error above the mapped region
  function automatic logic [33:0] expRsp(logic [31:0] a, mmic_pkg::mmic_burst_t b, logic [3:0] n);
    logic [31:0] ba;
    ba = (b == mmic_pkg::BURST_FIXED) ? a : a + {26'h0, n, 2'b00};
    if (b == mmic_pkg::BURST_WRAP) ba = {a[31:4], ba[3:0]};
    if (a >= 32'h00010000) return {mmic_pkg::RSP_DECERR, 32'h0};
    return {(ba[11:8] == 4'hf) ? mmic_pkg::RSP_SLVERR : mmic_pkg::RSP_OKAY, ba ^ 32'h5a5a0000};
  endfunction
  // Present one request until taken or lim cycles pass; notes the expected answer
  task automatic issue(input logic [31:0] a, input mmic_pkg::mmic_burst_t b, input logic [3:0] n,
                       input bit ecc, input int lim, output bit taken);
    taken = 1'b0;
    uReqValid = 1'b1;
    uReqAddr = a;
    uReqBurst = b;
    uReqBeat = n;
    uReqWrite = 1'($random(seed));
    uReqWdata = 32'($random(seed));
    for (int i = 0; i < lim && !taken; i++) begin
      @(negedge clk);
      taken = acc;
    end
    if (taken) begin
      expQ.push_back(ecc ? {mmic_pkg::RSP_DECERR, 32'h0} : expRsp(a, b, n));
      nErr += int'(expQ[$][33:32] != 2'h0);
      issued++;
    end else begin
      uReqValid = 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic idle(input int n);
    uReqValid = 1'b0;
    repeat (n) @(negedge clk);
  endtask
  task automatic drain();
    for (int i = 0; i < 600 && expQ.size() != 0; i++) @(negedge clk);
    chk(34'(expQ.size()), 34'h0);
  endtask
  // Reset, then count cycles until requests are allowed
  task automatic do_reset();
    int n;
    nrst = 1'b0;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    n = 0;
    while (running !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(34'(n), 34'h20);
    issued = 0;
    nErr = 0;
  endtask
  // Handshake samples at the rising edge
  always @(posedge clk) begin
    acc   <= uReqValid && uReqReady;
    sTake <= sCmdValid && sCmdReady;
    rTake <= sRspValid && sRspReady;
    sAddr <= sCmd.addr;
    cyc++;
    if (cyc == 40000) begin
      nMismatch++;
      end_of_test();
    end
  end
  // Far-side slave: random accept, in-order answers held until taken
  always @(negedge clk) begin
    if (sTake) slvQ.push_back(sAddr);
    if (rTake) begin
      sRspValid = 1'b0;
      sRspData = ~sRspData;
    end else if (!sRspValid && slvQ.size() != 0 && !stall && 1'($random(seed))) begin
      sRspValid = 1'b1;
      sRspData = slvQ[0] ^ 32'h5a5a0000;
      sRspErr = (slvQ[0][11:8] == 4'hf);
      void'(slvQ.pop_front());
    end
    sCmdReady = !stall && 1'($random(seed));
  end
  // Response monitor against the oldest note
  always @(negedge clk) begin
    if (uRspValid === 1'b1) begin
      if (expQ.size() == 0) chk({uRspCode, uRspData}, 34'h3ffffffff);
      else chk({uRspCode, uRspData}, expQ.pop_front());
    end
  end
  // Main sequence
  initial begin
    {uReqValid, uReqWrite, sCmdReady, sRspValid, sRspErr, eccInject, stall} = 7'h0;
    {uReqAddr, uReqWdata, sRspData} = 96'h0;
    {uReqBeat, uReqBurst, slvRstReqN, nrst} = 8'h02;
    do_reset();
    for (int i = 0; i < 4; i++) issue(32'h10 * i, mmic_pkg::BURST_INCR, 4'h3, 1'b0, 200, ok);
    idle(1);
    drain();
    do_reset();
    issue(32'h0000fffc, mmic_pkg::BURST_FIXED, 4'h0, 1'b0, 200, ok);
    issue(32'h00010000, mmic_pkg::BURST_FIXED, 4'h0, 1'b0, 200, ok);
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      issue({15'h0, r[16], 1'b0, r[14:2], 2'b00}, mmic_pkg::mmic_burst_t'(i % 3), r[20:17], 1'b0, 200, ok);
      if (r[21]) idle(1);
    end
    idle(1);
    drain();
    eccInject = 1'b1;
    issue(32'h00000040, mmic_pkg::BURST_INCR, 4'h1, 1'b1, 200, ok);
    idle(1);
    drain();
    eccInject = 1'b0;
    // Stall the slave and fill the buffering until refused
    stall = 1'b1;
    nAcc = 0;
    ok = 1'b1;
    while (ok && nAcc < 40) begin
      issue(32'h100 + 32'(nAcc * 4), mmic_pkg::BURST_FIXED, 4'h0, 1'b0, 30, ok);
      nAcc += int'(ok);
    end
    chk(34'(nAcc > 2), 34'h1);
    slvRstReqN = 1'b0;
    repeat (5) @(negedge clk);
    chk({33'h0, slvRstN}, 34'h1);
    stall = 1'b0;
    drain();
    for (int i = 0; i < 50 && slvRstN !== 1'b0; i++) @(negedge clk);
    chk({33'h0, slvRstN}, 34'h0);
    slvRstReqN = 1'b1;
    chk({2'h0, dbgCmdCount}, 34'(issued));
    chk({2'h0, dbgRspCount}, 34'(issued));
    chk({2'h0, dbgErrCount}, 34'(nErr));
    chk(34'(dbgBusyCycles != 32'h0), 34'h1);
    end_of_test();
  end
endmodule
